// *** hw/frp_sequencer.sv ***
// Hard restart and power-on sequencer for a serial flash device
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

module frp_sequencer #(
  parameter int unsigned PROGRAM_CYC = frp_pkg::REC_PROGRAM_CYC,
  parameter int unsigned SMALL_ERASE_CYC = frp_pkg::REC_SMALL_ERASE_CYC,
  parameter int unsigned BLOCK_ERASE_CYC = frp_pkg::REC_BLOCK_ERASE_CYC,
  parameter int unsigned CHIP_ERASE_CYC = frp_pkg::REC_CHIP_ERASE_CYC,
  parameter int unsigned STATUS_WRITE_CYC = frp_pkg::REC_STATUS_WRITE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Device pins, active low restart and select
  input wire logic restart_n_in,
  input wire logic select_n_in,
  // Power-on detector, high when supply above write inhibit threshold
  input wire logic supply_ok_in,
  // Core status
  input wire frp_pkg::frp_op_t op_kind_in,
  input wire logic erase_suspended_in,
  input wire frp_pkg::frp_op_t suspended_kind_in,
  input wire logic so_data_in,
  input wire logic so_drive_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Serial output pin
  output logic so_out,
  output logic so_oe_out,
  // Core control
  output logic core_reset_out,
  output logic abort_op_out,
  output logic cmd_enable_out,
  output logic busy_out,
  output logic deep_power_down_out,
  output logic write_latch_flag_out,
  output logic op_in_progress_flag_out,
  output logic addr_4byte_out,
  output logic [7:0] lock_out
);

  localparam logic [frp_pkg::CNT_W-1:0] PULSE_LAST = frp_pkg::CNT_W'(frp_pkg::RESTART_PULSE_CYC - 1);
  localparam logic [frp_pkg::CNT_W-1:0] POWER_ON_LAST = frp_pkg::CNT_W'(frp_pkg::POWER_ON_REC_CYC - 1);

  frp_pkg::frp_state_t state;
  frp_pkg::frp_state_t next_state;
  logic [frp_pkg::CNT_W-1:0] cnt;
  logic [frp_pkg::CNT_W-1:0] next_cnt;
  frp_pkg::frp_op_t rec_class;
  frp_pkg::frp_op_t next_rec_class;
  frp_pkg::frp_flags_t flags;
  frp_pkg::frp_flags_t next_flags;
  logic abort_op;
  logic next_abort_op;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic so_q;
  logic next_so_q;
  logic ready;
  logic op_active;
  frp_pkg::frp_status_t status;

  // Recovery cycles, minus one, for a captured class
  function automatic logic [frp_pkg::CNT_W-1:0] rec_last(input frp_pkg::frp_op_t cls);
    int unsigned cyc;
    cyc = frp_pkg::REC_READ_CYC;
    case (cls)
      frp_pkg::FRP_OP_IDLE: cyc = frp_pkg::POWER_ON_REC_CYC;
      frp_pkg::FRP_OP_READ: cyc = frp_pkg::REC_READ_CYC;
      frp_pkg::FRP_OP_DECODE: cyc = frp_pkg::REC_DECODE_CYC;
      frp_pkg::FRP_OP_PROGRAM: cyc = PROGRAM_CYC;
      frp_pkg::FRP_OP_SMALL_ERASE: cyc = SMALL_ERASE_CYC;
      frp_pkg::FRP_OP_BLOCK_ERASE: cyc = BLOCK_ERASE_CYC;
      frp_pkg::FRP_OP_CHIP_ERASE: cyc = CHIP_ERASE_CYC;
      frp_pkg::FRP_OP_STATUS_WRITE: cyc = STATUS_WRITE_CYC;
      default: cyc = frp_pkg::REC_READ_CYC;
    endcase
    return frp_pkg::CNT_W'(cyc - 1);
  endfunction

  // Decode of ready and in-flight work
  assign ready = (state == frp_pkg::FRP_ST_READY);
  assign op_active = (op_kind_in != frp_pkg::FRP_OP_IDLE) && (op_kind_in != frp_pkg::FRP_OP_READ)
    && (op_kind_in != frp_pkg::FRP_OP_DECODE);

  // Sequencer and volatile flags, next values
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rec_class = rec_class;
    next_flags = flags;
    next_abort_op = 1'b0;
    if (!supply_ok_in) begin
      // Supply low: everything held at defaults
      next_state = frp_pkg::FRP_ST_SUPPLY_LOW;
      next_cnt = '0;
      next_flags = frp_pkg::FLAGS_RESET;
      next_rec_class = frp_pkg::FRP_OP_IDLE;
    end else begin
      case (state)
        frp_pkg::FRP_ST_SUPPLY_LOW: begin
          next_state = frp_pkg::FRP_ST_RECOVER;
          next_cnt = POWER_ON_LAST;
          next_rec_class = frp_pkg::FRP_OP_IDLE;
        end
        frp_pkg::FRP_ST_READY: begin
          if (!restart_n_in) begin
            next_state = frp_pkg::FRP_ST_PULSE;
            next_cnt = '0;
            // Suspended erase sets the recovery class
            next_rec_class = erase_suspended_in ? suspended_kind_in : op_kind_in;
          end else if (reg_write_in && reg_addr_in == frp_pkg::REG_CTRL) begin
            if (reg_wdata_in[frp_pkg::CTRL_WL_SET]) begin
              next_flags.write_latch_flag = 1'b1;
            end else if (reg_wdata_in[frp_pkg::CTRL_WL_CLR]) begin
              next_flags.write_latch_flag = 1'b0;
            end
            if (reg_wdata_in[frp_pkg::CTRL_ADDR4_ENTER]) begin
              next_flags.addr_4byte = 1'b1;
            end else if (reg_wdata_in[frp_pkg::CTRL_ADDR4_EXIT]) begin
              next_flags.addr_4byte = 1'b0;
            end
          end else if (reg_write_in && reg_addr_in == frp_pkg::REG_LOCK) begin
            next_flags.lock = reg_wdata_in[7:0];
          end
        end
        frp_pkg::FRP_ST_PULSE: begin
          if (restart_n_in) begin
            // Pulse too short, no reset, straight back to ready, also when entered from recovery
            next_state = frp_pkg::FRP_ST_READY;
          end else if (cnt == PULSE_LAST) begin
            next_state = frp_pkg::FRP_ST_HELD;
            next_flags = frp_pkg::FLAGS_RESET;
            next_abort_op = op_active;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        frp_pkg::FRP_ST_HELD: begin
          if (restart_n_in) begin
            next_state = frp_pkg::FRP_ST_RECOVER;
            next_cnt = rec_last(rec_class);
          end
        end
        frp_pkg::FRP_ST_RECOVER: begin
          if (!restart_n_in) begin
            // Restart again, class kept from the first one
            next_state = frp_pkg::FRP_ST_PULSE;
            next_cnt = '0;
          end else if (cnt == '0) begin
            next_state = frp_pkg::FRP_ST_READY;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
        default: begin
          next_state = frp_pkg::FRP_ST_SUPPLY_LOW;
          next_cnt = '0;
        end
      endcase
    end
  end

  // Sequencer and volatile flags, registers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state <= frp_pkg::FRP_ST_SUPPLY_LOW;
      cnt <= '0;
      rec_class <= frp_pkg::FRP_OP_IDLE;
      flags <= frp_pkg::FLAGS_RESET;
      abort_op <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rec_class <= next_rec_class;
      flags <= next_flags;
      abort_op <= next_abort_op;
    end
  end

  // Status word
  always_comb begin
    status = '0;
    status.rec_class = rec_class;
    status.state = state;
    status.lock = flags.lock;
    status.addr_4byte = flags.addr_4byte;
    status.op_in_progress_flag = !ready;
    status.write_latch_flag = flags.write_latch_flag;
    status.busy = !ready;
  end

  // Register read data and serial output, next values
  always_comb begin
    next_rdata = '0;
    if (reg_read_in) begin
      case (reg_addr_in)
        frp_pkg::REG_STATUS: next_rdata = status;
        frp_pkg::REG_LOCK: next_rdata = {24'h00_0000, flags.lock};
        default: next_rdata = '0;
      endcase
    end
    next_so_q = so_data_in;
  end

  // Read data and serial output, registers
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata <= frp_pkg::RDATA_RESET;
      so_q <= 1'b0;
    end else begin
      rdata <= next_rdata;
      so_q <= next_so_q;
    end
  end

  // Outputs
  assign reg_rdata_out = rdata;
  assign so_out = so_q;
  assign so_oe_out = so_drive_in && restart_n_in && ready && !select_n_in;
  assign core_reset_out = (state == frp_pkg::FRP_ST_SUPPLY_LOW) || (state == frp_pkg::FRP_ST_HELD);
  assign abort_op_out = abort_op;
  assign cmd_enable_out = ready && restart_n_in && supply_ok_in;
  assign busy_out = !ready;
  assign deep_power_down_out = 1'b0;
  assign write_latch_flag_out = flags.write_latch_flag;
  assign op_in_progress_flag_out = !ready;
  assign addr_4byte_out = flags.addr_4byte;
  assign lock_out = flags.lock;

endmodule

`default_nettype wire

// *** hw/frp_pkg.sv ***
// Package of constants and types for the flash restart and power-on sequencer
package frp_pkg;
  // Clock rate
  localparam int unsigned CLK_MHZ = 100;

  // Times in their own units
  localparam int unsigned RESTART_PULSE_MIN_US = 10;
  localparam int unsigned RESTART_TO_SELECT_GAP_US = 10;
  localparam int unsigned POWER_ON_RECOVERY_US = 35;
  localparam int unsigned REC_READ_US = 35;
  localparam int unsigned REC_DECODE_US = 40;
  localparam int unsigned REC_PROGRAM_US = 310;
  localparam int unsigned REC_SMALL_ERASE_MS = 12;
  localparam int unsigned REC_BLOCK_ERASE_MS = 25;
  localparam int unsigned REC_CHIP_ERASE_MS = 100;
  localparam int unsigned REC_STATUS_WRITE_MS = 40;

  // Cycle counts derived from the clock rate (least times, exact multiples)
  localparam int unsigned RESTART_PULSE_CYC = RESTART_PULSE_MIN_US * CLK_MHZ;
  localparam int unsigned POWER_ON_REC_CYC = POWER_ON_RECOVERY_US * CLK_MHZ;
  localparam int unsigned REC_READ_CYC = REC_READ_US * CLK_MHZ;
  localparam int unsigned REC_DECODE_CYC = REC_DECODE_US * CLK_MHZ;
  localparam int unsigned REC_PROGRAM_CYC = REC_PROGRAM_US * CLK_MHZ;
  localparam int unsigned REC_SMALL_ERASE_CYC = REC_SMALL_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned REC_BLOCK_ERASE_CYC = REC_BLOCK_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned REC_CHIP_ERASE_CYC = REC_CHIP_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned REC_STATUS_WRITE_CYC = REC_STATUS_WRITE_MS * 1000 * CLK_MHZ;

  // Counter width, holds the longest recovery
  localparam int unsigned CNT_W = 24;

  // Register map, byte addresses
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_LOCK = 8'h08;

  // Control register pulse bits
  localparam int unsigned CTRL_WL_SET = 0;
  localparam int unsigned CTRL_WL_CLR = 1;
  localparam int unsigned CTRL_ADDR4_ENTER = 2;
  localparam int unsigned CTRL_ADDR4_EXIT = 3;

  // Reset values of the volatile state
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Operation the core is executing, also the recovery class
  typedef enum logic [2:0] {
    FRP_OP_IDLE = 3'b000,
    FRP_OP_READ = 3'b001,
    FRP_OP_DECODE = 3'b010,
    FRP_OP_PROGRAM = 3'b011,
    FRP_OP_SMALL_ERASE = 3'b100,
    FRP_OP_BLOCK_ERASE = 3'b101,
    FRP_OP_CHIP_ERASE = 3'b110,
    FRP_OP_STATUS_WRITE = 3'b111
  } frp_op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    FRP_ST_SUPPLY_LOW = 3'b000,
    FRP_ST_READY = 3'b001,
    FRP_ST_PULSE = 3'b010,
    FRP_ST_HELD = 3'b011,
    FRP_ST_RECOVER = 3'b100
  } frp_state_t;

  // Volatile flags carried together
  typedef struct packed {
    logic write_latch_flag;
    logic addr_4byte;
    logic [7:0] lock;
  } frp_flags_t;

  // Status word layout
  typedef struct packed {
    logic [13:0] zero;
    frp_op_t rec_class;
    frp_state_t state;
    logic [7:0] lock;
    logic addr_4byte;
    logic op_in_progress_flag;
    logic write_latch_flag;
    logic busy;
  } frp_status_t;

  localparam frp_flags_t FLAGS_RESET = '{write_latch_flag: 1'b0, addr_4byte: 1'b0, lock: LOCK_RESET};
endpackage

// *** verification/frp_monitor.sv ***
// Port checker for the restart sequencer
`timescale 1ns/100ps
`default_nettype none
module frp_monitor(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic restart_n_in,
  input wire logic select_n_in,
  input wire logic supply_ok_in,
  input wire logic so_drive_in,
  input wire logic so_oe_out,
  input wire logic core_reset_out,
  input wire logic abort_op_out,
  input wire logic cmd_enable_out,
  input wire logic busy_out,
  input wire logic deep_power_down_out,
  input wire logic write_latch_flag_out,
  input wire logic addr_4byte_out,
  input wire logic [7:0] lock_out
);
  logic [15:0] low_cnt;
  // Length of the present restart low pulse
  always_ff @(posedge clk_sys_in) begin
    low_cnt <= (reset_in || restart_n_in) ? 16'h0000 : low_cnt + {15'h0000, ~&low_cnt};
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_release;
    $rose(restart_n_in) && core_reset_out;
  endsequence
  sequence s_recover;
    (busy_out && !cmd_enable_out) [*8];
  endsequence
  property p_so_hiz;
    (!restart_n_in || select_n_in || !so_drive_in || busy_out) |-> !so_oe_out;
  endproperty
  a_so_hiz: assert property (p_so_hiz) else $error("serial output driven while not allowed");
  property p_supply;
    !supply_ok_in |-> !cmd_enable_out ##1 (core_reset_out && busy_out);
  endproperty
  a_supply: assert property (p_supply) else $error("low supply did not hold logic in reset");
  property p_busy;
    busy_out |-> !cmd_enable_out;
  endproperty
  a_busy: assert property (p_busy) else $error("commands enabled while busy");
  property p_dpd;
    !deep_power_down_out;
  endproperty
  a_dpd: assert property (p_dpd) else $error("deep power down entered");
  property p_flags;
    core_reset_out |=> !write_latch_flag_out && !addr_4byte_out && lock_out == 8'h00;
  endproperty
  a_flags: assert property (p_flags) else $error("volatile flags kept through reset");
  property p_pulse;
    $rose(core_reset_out) && supply_ok_in && $past(supply_ok_in) && !$past(reset_in) |-> low_cnt >= 16'h03E8;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset taken on a short pulse");
  property p_abort;
    abort_op_out |-> !restart_n_in ##1 !abort_op_out;
  endproperty
  a_abort: assert property (p_abort) else $error("abort pulse malformed");
  property p_recover;
    s_release |-> s_recover;
  endproperty
  a_recover: assert property (p_recover) else $error("ready too soon after restart");
endmodule
bind frp_sequencer frp_monitor u_mon(.clk_sys_in, .reset_in, .restart_n_in, .select_n_in, .supply_ok_in,
  .so_drive_in, .so_oe_out, .core_reset_out, .abort_op_out, .cmd_enable_out, .busy_out, .deep_power_down_out,
  .write_latch_flag_out, .addr_4byte_out, .lock_out);
`default_nettype wire

// *** verification/frp_host_model.sv ***
// Host controller model driving restart and select
`timescale 1ns/100ps
`default_nettype none
module frp_host_model(
  input wire logic clk_sys_in,
  input wire logic busy_in,
  output logic restart_n_out,
  output logic select_n_out
);
  initial begin
    restart_n_out = 1'b1;
    select_n_out = 1'b1;
  end
  // Pulse restart, then select only after recovery and gap
  task automatic restart(input int low_cyc, output int rec);
    select_n_out <= 1'b1;
    restart_n_out <= 1'b0;
    repeat (low_cyc) @(posedge clk_sys_in);
    restart_n_out <= 1'b1;
    rec = 0;
    while (busy_in !== 1'b0 && rec < 20000) begin
      @(posedge clk_sys_in);
      rec++;
    end
    repeat (rec < 1000 ? 1000 - rec : 0) @(posedge clk_sys_in);
    select_n_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verification/flash_hw_reset_and_power_on_tb.sv ***
// Self-checking bench for the restart sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_hw_reset_and_power_on_tb;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, supply_ok_in = 1'b1, erase_suspended_in = 1'b0;
  logic so_data_in = 1'b0, so_drive_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0, rd_d = 1'b0, so_d = 1'b0;
  frp_pkg::frp_op_t op_kind_in = frp_pkg::FRP_OP_IDLE, suspended_kind_in = frp_pkg::FRP_OP_BLOCK_ERASE;
  logic [7:0] reg_addr_in = 8'h00, lock_out, lock;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out;
  logic [63:0] note, exp_q[$];
  logic restart_n_in, select_n_in, so_out, so_oe_out, core_reset_out, abort_op_out, cmd_enable_out, busy_out;
  logic deep_power_down_out, write_latch_flag_out, op_in_progress_flag_out, addr_4byte_out;
  int seed = 36724, miscompares = 0, check_count = 0, rec, abort_seen;
  int recs[8] = '{3500, 50, 4000, 50, 50, 50, 50, 50};
  always #5 clk_sys_in = ~clk_sys_in;
  frp_sequencer #(.PROGRAM_CYC(50), .SMALL_ERASE_CYC(50), .BLOCK_ERASE_CYC(50), .CHIP_ERASE_CYC(50),
    .STATUS_WRITE_CYC(50)) u_dut(.clk_sys_in, .reset_in, .restart_n_in, .select_n_in, .supply_ok_in,
    .op_kind_in, .erase_suspended_in, .suspended_kind_in, .so_data_in, .so_drive_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .so_out, .so_oe_out, .core_reset_out,
    .abort_op_out, .cmd_enable_out, .busy_out, .deep_power_down_out, .write_latch_flag_out,
    .op_in_progress_flag_out, .addr_4byte_out, .lock_out);
  frp_host_model u_host(.clk_sys_in, .busy_in(busy_out), .restart_n_out(restart_n_in), .select_n_out(select_n_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    check_count++;
    if (seen !== expd) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_write_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [63:0] n);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    exp_q.push_back(n);
    @(posedge clk_sys_in);
    reg_read_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic wait_ready();
    rec = 0;
    while (busy_out !== 1'b0 && rec < 20000) begin
      @(posedge clk_sys_in);
      rec++;
    end
    if (rec >= 20000) begin
      miscompares++;
      print_verdict();
    end
  endtask
  function automatic logic [63:0] st(input logic wl, input logic a4, input logic [7:0] lk);
    return {32'h0000_7FFF, 17'h00000, frp_pkg::FRP_ST_READY, lk, a4, 1'b0, wl, 1'b0};
  endfunction
  // Read results against oldest note, abort count, serial data
  always @(posedge clk_sys_in) begin
    if (rd_d) begin
      note = exp_q.pop_front();
      check(reg_rdata_out & note[63:32], note[31:0]);
    end
    if (!reset_in) check(32'(so_out), 32'(so_d));
    so_d <= so_data_in;
    rd_d <= reg_read_in;
    so_data_in <= 1'($random(seed));
    if (abort_op_out === 1'b1) abort_seen++;
  end
  initial begin
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    wait_ready();
    check(32'(rec >= 3500 && rec <= 3504), 32'h1);
    check(32'(deep_power_down_out), 32'h0);
    rd(frp_pkg::REG_STATUS, st(1'b0, 1'b0, 8'h00));
    lock = 8'($random(seed));
    wr(frp_pkg::REG_CTRL, 32'h0000_0005);
    wr(frp_pkg::REG_LOCK, {24'h000000, lock});
    rd(frp_pkg::REG_CTRL, 64'hFFFF_FFFF_0000_0000);
    rd(8'h0C, 64'hFFFF_FFFF_0000_0000);
    u_host.restart(600, rec);
    rd(frp_pkg::REG_STATUS, st(1'b1, 1'b1, lock));
    check(32'({write_latch_flag_out, addr_4byte_out, lock_out}), 32'({2'b11, lock}));
    // Restart over every operation kind, read one as suspended erase
    for (int k = 0; k < 8; k++) begin
      wr(frp_pkg::REG_CTRL, 32'h0000_0005);
      op_kind_in <= frp_pkg::frp_op_t'(k);
      erase_suspended_in <= (k == 1);
      @(posedge clk_sys_in);
      abort_seen = 0;
      u_host.restart(1010, rec);
      check(32'(abort_seen), 32'(k >= 3));
      check(32'(rec >= recs[k] && rec <= recs[k] + 4), 32'h1);
      rd(frp_pkg::REG_STATUS, st(1'b0, 1'b0, 8'h00));
      check(32'(so_oe_out), 32'h1);
    end
    // Supply loss, then a write refused during recovery
    wr(frp_pkg::REG_LOCK, {24'h000000, lock});
    supply_ok_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    check(32'({cmd_enable_out, core_reset_out}), 32'h1);
    supply_ok_in <= 1'b1;
    @(posedge clk_sys_in);
    wr(frp_pkg::REG_CTRL, 32'h0000_0001);
    wait_ready();
    rd(frp_pkg::REG_STATUS, st(1'b0, 1'b0, 8'h00));
    print_verdict();
  end
endmodule
`default_nettype wire
